// *** design/sor_pkg.sv ***
package sor_pkg;
    // Register offsets (word aligned byte addresses)
    // Flags keep their word index; the bus address is four times it
    localparam int SOR_FLAGS_IDX = 3;
    localparam logic [7:0] SOR_FLAGS_OFF = 8'(4 * SOR_FLAGS_IDX);
    localparam logic [7:0] SOR_CFG_OFF = 8'h10;
    localparam logic [7:0] SOR_DIR_OFF = 8'h14;
    localparam logic [7:0] SOR_IRQ_STAT_OFF = 8'h18;
    localparam logic [7:0] SOR_IRQ_CLR_OFF = 8'h1C;
    localparam logic [7:0] SOR_IRQ_EN_OFF = 8'h20;
    localparam logic [7:0] SOR_PINS_OFF = 8'h24;
    // Flag bit positions
    localparam int SOR_C_BIT = 0;
    localparam int SOR_HC_BIT = 1;
    localparam int SOR_Z_BIT = 2;
    localparam int SOR_PD_BIT = 3;
    localparam int SOR_TO_BIT = 4;
    localparam int SOR_PG_BIT = 5;
    localparam int SOR_WF_BIT = 7;
    // Config bit positions, timer clock pin, reset values and bus responses
    localparam int SOR_WAKE_DIS_BIT = 7;
    localparam int SOR_PU_DIS_BIT = 6;
    localparam int SOR_TCS_BIT = 5;
    localparam int SOR_TCK_PIN = 2;
    localparam logic [7:0] SOR_CFG_RST = 8'hFF;
    localparam logic [7:0] SOR_FLAGS_RST = 8'h18;
    localparam logic [7:0] SOR_DIR_RST = 8'hFF;
    localparam logic [1:0] SOR_RESP_OK = 2'b00;
    localparam logic [1:0] SOR_RESP_ERR = 2'b10;
    // Interrupt bits: sleep, wdt timeout, wake
    localparam int SOR_EV_W = 3;

    typedef enum {
        SOR_OP_NONE, SOR_OP_ADD, SOR_OP_SUB, SOR_OP_RRF, SOR_OP_RLF,
        SOR_OP_LOGIC, SOR_OP_CFG_LOAD, SOR_OP_WDT_CLR, SOR_OP_SLEEP
    } sor_op_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] operand;
        logic [3:0] op;
    } sor_instr_t;
endpackage

// *** design/sor_status_option.sv ***
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sor_status_option
    import sor_pkg::*;
#(
    parameter int PINS = 6
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Core execution side
    input wire logic instr_valid_in,
    input wire sor_instr_t instr_in,
    input wire logic wdt_timeout_in,
    input wire logic wake_event_in,
    input wire logic [PINS-1:0] pin_direction_ctrl_in,
    // Pin control, result, flags and interrupt
    output logic [PINS-1:0] pullup_en_out,
    output logic [PINS-1:0] wake_en_out,
    output logic [PINS-1:0] pin_oe_n_out,
    output logic [7:0] result_out,
    output logic [7:0] processor_flags_out,
    output logic irq_out,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    if (PINS <= SOR_TCK_PIN || PINS > 8) begin : g_bad_pins
        $error("PINS out of range");
    end

    logic [7:0] flags_reg;
    logic [7:0] cfg_reg;
    logic [PINS-1:0] dir_reg;
    logic [SOR_EV_W-1:0] ev_stat_reg, ev_en_reg;
    logic [7:0] aw_reg;
    logic aw_full_reg, w_full_reg;
    logic [31:0] wd_reg;
    logic [PINS-1:0] pins_sync1_reg, pins_sync2_reg;

    // Arithmetic
    wire is_add = instr_valid_in && instr_in.op == 4'(SOR_OP_ADD);
    wire is_sub = instr_valid_in && instr_in.op == 4'(SOR_OP_SUB);
    wire is_rrf = instr_valid_in && instr_in.op == 4'(SOR_OP_RRF);
    wire is_rlf = instr_valid_in && instr_in.op == 4'(SOR_OP_RLF);
    wire is_log = instr_valid_in && instr_in.op == 4'(SOR_OP_LOGIC);
    wire is_cfg = instr_valid_in && instr_in.op == 4'(SOR_OP_CFG_LOAD);
    wire is_clr = instr_valid_in && instr_in.op == 4'(SOR_OP_WDT_CLR);
    wire is_slp = instr_valid_in && instr_in.op == 4'(SOR_OP_SLEEP);
    wire [8:0] add_sum = {1'b0, instr_in.operand} + {1'b0, instr_in.acc};
    wire [8:0] sub_dif = {1'b0, instr_in.operand} + {1'b0, ~instr_in.acc}
        + 9'h001;
    wire [4:0] add_lo = {1'b0, instr_in.operand[3:0]}
        + {1'b0, instr_in.acc[3:0]};
    // sub half carry, one means no borrow
    wire [4:0] sub_lo = {1'b0, instr_in.operand[3:0]}
        + {1'b0, ~instr_in.acc[3:0]} + 5'h01;
    wire [7:0] rrf_res = {flags_reg[SOR_C_BIT], instr_in.operand[7:1]};
    wire [7:0] rlf_res = {instr_in.operand[6:0], flags_reg[SOR_C_BIT]};

    // Bus decode
    wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire wr_flags = wr_fire && aw_reg == SOR_FLAGS_OFF;
    wire wr_dir = wr_fire && aw_reg == SOR_DIR_OFF;
    wire wr_clr = wr_fire && aw_reg == SOR_IRQ_CLR_OFF;
    wire wr_en = wr_fire && aw_reg == SOR_IRQ_EN_OFF;
    wire wr_ok = wr_flags || wr_dir || wr_clr || wr_en;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_ok = s_axi_araddr == SOR_FLAGS_OFF
        || s_axi_araddr == SOR_DIR_OFF || s_axi_araddr == SOR_IRQ_STAT_OFF
        || s_axi_araddr == SOR_IRQ_EN_OFF || s_axi_araddr == SOR_PINS_OFF;

    // Flags next value
    logic [7:0] fl_next;
    always_comb begin
        fl_next = flags_reg;
        if (wr_flags && wd_reg[0]) begin
            fl_next[SOR_PG_BIT] = wd_reg[SOR_PG_BIT];
            fl_next[SOR_Z_BIT] = wd_reg[SOR_Z_BIT];
            fl_next[SOR_HC_BIT] = wd_reg[SOR_HC_BIT];
            fl_next[SOR_C_BIT] = wd_reg[SOR_C_BIT];
        end
        if (is_add) begin
            fl_next[SOR_C_BIT] = add_sum[8];
            fl_next[SOR_HC_BIT] = add_lo[4];
            fl_next[SOR_Z_BIT] = add_sum[7:0] == 8'h00;
        end
        if (is_sub) begin
            fl_next[SOR_C_BIT] = sub_dif[8];
            fl_next[SOR_HC_BIT] = sub_lo[4];
            fl_next[SOR_Z_BIT] = sub_dif[7:0] == 8'h00;
        end
        if (is_rrf) begin
            fl_next[SOR_C_BIT] = instr_in.operand[0];
        end
        if (is_rlf) begin
            fl_next[SOR_C_BIT] = instr_in.operand[7];
        end
        if (is_log) begin
            fl_next[SOR_Z_BIT] = instr_in.operand == 8'h00;
        end
        if (is_clr) begin
            fl_next[SOR_TO_BIT] = 1'b1;
            fl_next[SOR_PD_BIT] = 1'b1;
        end
        if (is_slp) begin
            fl_next[SOR_TO_BIT] = 1'b1;
            fl_next[SOR_PD_BIT] = 1'b0;
        end
        if (wdt_timeout_in) begin
            fl_next[SOR_TO_BIT] = 1'b0;
        end
        if (wake_event_in) begin
            fl_next[SOR_WF_BIT] = 1'b1;
        end
    end

    wire [SOR_EV_W-1:0] ev_now = {wake_event_in, wdt_timeout_in, is_slp};
    // Set wins over clear
    wire [SOR_EV_W-1:0] ev_next = (ev_stat_reg
        & ~(wr_clr ? wd_reg[SOR_EV_W-1:0] : '0)) | ev_now;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flags_reg <= SOR_FLAGS_RST;
            cfg_reg <= SOR_CFG_RST;
            dir_reg <= PINS'(SOR_DIR_RST);
            ev_stat_reg <= '0;
            ev_en_reg <= '0;
            result_out <= 8'h00;
        end else begin
            flags_reg <= fl_next;
            if (is_cfg) begin
                cfg_reg <= instr_in.acc;
            end
            if (wr_dir) begin
                dir_reg <= wd_reg[PINS-1:0];
            end
            ev_stat_reg <= ev_next;
            if (wr_en) begin
                ev_en_reg <= wd_reg[SOR_EV_W-1:0];
            end
            result_out <= is_add ? add_sum[7:0] : is_sub ? sub_dif[7:0]
                : is_rrf ? rrf_res : is_rlf ? rlf_res : result_out;
        end
    end

    always_ff @(posedge clk_in) begin
        pins_sync1_reg <= pin_direction_ctrl_in;
        pins_sync2_reg <= pins_sync1_reg;
    end

    // Pin functions
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            wire tck = g == SOR_TCK_PIN && cfg_reg[SOR_TCS_BIT];
            wire is_in = dir_reg[g] || tck;
            assign pullup_en_out[g] = is_in && !cfg_reg[SOR_PU_DIS_BIT];
            assign wake_en_out[g] = is_in && !cfg_reg[SOR_WAKE_DIS_BIT];
            assign pin_oe_n_out[g] = is_in;
        end
    endgenerate

    assign processor_flags_out = flags_reg;
    assign irq_out = |(ev_stat_reg & ev_en_reg);

    // AXI4-Lite slave
    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_reg <= 8'h00;
            wd_reg <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SOR_RESP_OK;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SOR_RESP_OK;
        end else begin
            if (s_axi_awvalid && !aw_full_reg) begin
                aw_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
            end
            if (s_axi_wvalid && !w_full_reg) begin
                wd_reg <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
                w_full_reg <= 1'b1;
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? SOR_RESP_OK : SOR_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rd_ok ? SOR_RESP_OK : SOR_RESP_ERR;
                case (s_axi_araddr)
                    SOR_FLAGS_OFF: s_axi_rdata <= {24'h00_0000, flags_reg};
                    SOR_DIR_OFF: s_axi_rdata <= 32'(dir_reg);
                    SOR_IRQ_STAT_OFF: s_axi_rdata <= 32'(ev_stat_reg);
                    SOR_IRQ_EN_OFF: s_axi_rdata <= 32'(ev_en_reg);
                    SOR_PINS_OFF: s_axi_rdata <= 32'(pins_sync2_reg);
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/sor_checker_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module sor_checker
    import sor_pkg::*;
#(parameter int PINS = 6) (
    // Watched ports
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic instr_valid_in,
    input wire sor_instr_t instr_in,
    input wire logic wdt_timeout_in,
    input wire logic [PINS-1:0] pullup_en_out,
    input wire logic [PINS-1:0] wake_en_out,
    input wire logic [PINS-1:0] pin_oe_n_out,
    input wire logic [7:0] processor_flags_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    wire logic [3:0] op = instr_valid_in ? instr_in.op : 4'd0;
    wire logic [4:0] lo = instr_in.operand[3:0] + instr_in.acc[3:0];
    wire logic add_hc = lo[4];
    wire logic sub_hc = instr_in.operand[3:0] >= instr_in.acc[3:0];
    property p_reset_cfg;
        $rose(rst_n_in) |-> (pullup_en_out | wake_en_out) == '0
            && &pin_oe_n_out;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg)
        else $error("config not ones");
    property p_load;
        op == 4'd6 && instr_in.acc[7:6] == 2'b11
            |=> (pullup_en_out | wake_en_out) == '0;
    endproperty
    a_load: assert property (p_load)
        else $error("config load lost");
    property p_pin_out;
        (~pin_oe_n_out & (pullup_en_out | wake_en_out)) == '0;
    endproperty
    a_pin_out: assert property (p_pin_out)
        else $error("output pin keeps pull");
    property p_tclk;
        op == 4'd6 && instr_in.acc[SOR_TCS_BIT]
            |=> pin_oe_n_out[SOR_TCK_PIN];
    endproperty
    a_tclk: assert property (p_tclk)
        else $error("timer pin driven");
    property p_add_hc;
        op == 4'd1 |=> processor_flags_out[SOR_HC_BIT] == $past(add_hc);
    endproperty
    a_add_hc: assert property (p_add_hc)
        else $error("add half carry");
    property p_sub_hc;
        op == 4'd2 |=> processor_flags_out[SOR_HC_BIT] == $past(sub_hc);
    endproperty
    a_sub_hc: assert property (p_sub_hc)
        else $error("sub half carry");
    property p_wdt_clr;
        op == 4'd7 && !wdt_timeout_in |=> processor_flags_out[SOR_TO_BIT]
            && processor_flags_out[SOR_PD_BIT];
    endproperty
    a_wdt_clr: assert property (p_wdt_clr)
        else $error("clear left flags");
    property p_sleep;
        op == 4'd8 && !wdt_timeout_in |=> processor_flags_out[SOR_TO_BIT]
            && !processor_flags_out[SOR_PD_BIT];
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep left flags");
    property p_timeout;
        wdt_timeout_in |=> !processor_flags_out[SOR_TO_BIT];
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("timeout flag kept");
endmodule
bind sor_status_option sor_checker #(.PINS(PINS)) sor_checker_i (.*);
`default_nettype wire

// *** sim/sor_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sor_core_model
    import sor_pkg::*;
(
    // Execution side
    input wire logic clk_in,
    output logic instr_valid_out = 1'b0,
    output sor_instr_t instr_out = '0,
    output logic wdt_timeout_out = 1'b0,
    output logic wake_event_out = 1'b0
);
    task automatic exec(input logic [3:0] op, input logic [7:0] acc,
        input logic [7:0] opnd);
        @(posedge clk_in);
        instr_out <= '{acc, opnd, op};
        instr_valid_out <= 1'b1;
        @(posedge clk_in);
        // Released operands stop holding
        instr_out <= ~instr_out;
        instr_valid_out <= 1'b0;
        #1;
    endtask
    task automatic pulse(input logic tmo);
        @(posedge clk_in);
        wdt_timeout_out <= tmo;
        wake_event_out <= !tmo;
        @(posedge clk_in);
        wdt_timeout_out <= 1'b0;
        wake_event_out <= 1'b0;
        #1;
    endtask
endmodule
`default_nettype wire

// *** sim/sor_status_option_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sor_status_option_tb
    import sor_pkg::*;
;
    logic clk_in, rst_n_in = 1'b0;
    logic instr_valid_in, wdt_timeout_in, wake_event_in;
    sor_instr_t instr_in;
    logic [5:0] pin_direction_ctrl_in = 6'h2A;
    logic [5:0] pullup_en_out, wake_en_out, pin_oe_n_out;
    logic [7:0] result_out, processor_flags_out;
    logic irq_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, s_axi_wdata = '0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    int mismatches = 0, comparisons = 0, cycles = 0;
    sor_status_option #(.PINS(6)) sor_status_option_i (.*);
    sor_core_model sor_core_model_i (.clk_in(clk_in),
        .instr_valid_out(instr_valid_in), .instr_out(instr_in),
        .wdt_timeout_out(wdt_timeout_in), .wake_event_out(wake_event_in));
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [7:0] d,
        input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk_in);
        s_axi_awaddr <= a;
        s_axi_wdata <= 32'(d);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!done) begin
            @(posedge clk_in);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                chk(8'(s_axi_bresp), 8'(er));
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        #1;
    endtask
    task automatic axr(input logic [7:0] a, input logic [7:0] exp,
        input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge clk_in);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        while (!done) begin
            @(posedge clk_in);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                chk(s_axi_rdata[7:0], exp);
                chk(8'(s_axi_rresp), 8'(er));
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        #1;
    endtask
    task automatic t_cfg();
        logic [7:0] acc [5] = '{8'hC0, 8'h3F, 8'h1F, 8'h80, 8'h40};
        logic [7:0] m;
        axw(SOR_DIR_OFF, 8'h3B, SOR_RESP_OK);
        foreach (acc[i]) begin
            sor_core_model_i.exec(4'(SOR_OP_CFG_LOAD), acc[i], 8'h00);
            // Timer pin counts as input when forced
            m = acc[i][5] ? 8'h3F : 8'h3B;
            chk(8'(pullup_en_out), acc[i][6] ? 8'h00 : m);
            chk(8'(wake_en_out), acc[i][7] ? 8'h00 : m);
            chk(8'(pin_oe_n_out), m);
        end
        axr(SOR_CFG_OFF, 8'h00, SOR_RESP_ERR);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        axw(SOR_DIR_OFF, 8'h3B, SOR_RESP_OK);
        chk(8'(pullup_en_out | wake_en_out), 8'h00);
        chk(8'(pin_oe_n_out), 8'h3F);
        chk(processor_flags_out, SOR_FLAGS_RST);
    endtask
    task automatic t_arith();
        logic [3:0] op [5] = '{1, 1, 2, 2, 2};
        logic [7:0] a [5] = '{8'h08, 8'h08, 8'h01, 8'h01, 8'h00};
        logic [7:0] b [5] = '{8'h08, 8'h07, 8'h10, 8'h1F, 8'h00};
        logic [4:0] lo;
        logic hc;
        foreach (op[i]) begin
            sor_core_model_i.exec(op[i], a[i], b[i]);
            lo = b[i][3:0] + a[i][3:0];
            hc = op[i] == 3'd1 ? lo[4] : b[i][3:0] >= a[i][3:0];
            chk(result_out, op[i] == 3'd1 ? b[i] + a[i] : b[i] - a[i]);
            chk(8'(processor_flags_out[SOR_HC_BIT]), 8'(hc));
        end
        // Carry is one after the last subtract
        sor_core_model_i.exec(4'(SOR_OP_RLF), 8'h00, 8'h81);
        chk(result_out, 8'h03);
        sor_core_model_i.exec(4'(SOR_OP_RRF), 8'h00, 8'h02);
        chk(result_out, 8'h81);
        chk(8'(processor_flags_out[SOR_C_BIT]), 8'h00);
    endtask
    task automatic t_power();
        chk(8'(processor_flags_out[4:3]), 8'h03);
        sor_core_model_i.pulse(1'b1);
        chk(8'(processor_flags_out[4:3]), 8'h01);
        chk(8'(irq_out), 8'h00);
        axr(SOR_IRQ_STAT_OFF, 8'h02, SOR_RESP_OK);
        axw(SOR_IRQ_EN_OFF, 8'h02, SOR_RESP_OK);
        chk(8'(irq_out), 8'h01);
        axw(SOR_IRQ_CLR_OFF, 8'h02, SOR_RESP_OK);
        chk(8'(irq_out), 8'h00);
        sor_core_model_i.pulse(1'b0);
        axr(SOR_IRQ_STAT_OFF, 8'h04, SOR_RESP_OK);
        axr(SOR_PINS_OFF, 8'h2A, SOR_RESP_OK);
        sor_core_model_i.exec(4'(SOR_OP_WDT_CLR), 8'h00, 8'h00);
        chk(8'(processor_flags_out[4:3]), 8'h03);
        sor_core_model_i.exec(4'(SOR_OP_SLEEP), 8'h00, 8'h00);
        chk(8'(processor_flags_out[4:3]), 8'h02);
        axr(SOR_IRQ_STAT_OFF, 8'h05, SOR_RESP_OK);
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_cfg();
        t_arith();
        t_power();
        conclude();
    end
endmodule
`default_nettype wire
